// ---- hw/ccu_pkg.sv ----
package ccu_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_CAP_SRC   = 8'h04;
  localparam logic [7:0] OFF_HOLD_LOW  = 8'h08;
  localparam logic [7:0] OFF_HOLD_HIGH = 8'h0c;
  localparam logic [7:0] OFF_FLAG      = 8'h10;
  localparam logic [7:0] OFF_ENABLE    = 8'h14;
  localparam logic [7:0] OFF_TIMEBASE  = 8'h18;
  localparam logic [7:0] OFF_TIMER_SEL = 8'h1c;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTL_EN_BIT  = 7;
  localparam int CTL_OUT_BIT = 5;
  localparam int CTL_FMT_BIT = 4;

  // ----------------------------------------------------------------
  // mode encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET    = 4'h8;
  localparam logic [3:0] MODE_CMP_CLEAR  = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT   = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG   = 4'hb;

  localparam logic [3:0] PRESCALE_4  = 4'h3;
  localparam logic [3:0] PRESCALE_16 = 4'hf;

  // ----------------------------------------------------------------
  // capture source codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_PIN      = 4'h0;
  localparam logic [3:0] SRC_CMP_ONE  = 4'h1;
  localparam logic [3:0] SRC_CMP_TWO  = 4'h2;
  localparam logic [3:0] SRC_NUM_OSC  = 4'h3;
  localparam logic [3:0] SRC_PIN_CHG  = 4'h4;
  localparam logic [3:0] SRC_LC_ONE   = 4'h5;
  localparam logic [3:0] SRC_LC_TWO   = 4'h6;
  localparam logic [3:0] SRC_LC_THREE = 4'h7;
  localparam logic [3:0] SRC_LC_FOUR  = 4'h8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic is_capture(input logic [3:0] mode);
    return (mode >= MODE_CAP_FALL) && (mode <= MODE_CAP_RISE16);
  endfunction

  function automatic logic is_compare(input logic [3:0] mode);
    return (mode == MODE_CMP_TOGGLE) || ((mode >= MODE_CMP_SET) && (mode <= MODE_CMP_TRIG));
  endfunction
endpackage

// ---- hw/cap_event_detect.sv ----
`timescale 1ns/100ps
module cap_event_detect (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_source,
  input  wire logic [3:0] i_mode,
  input  wire logic       i_enable,
  input  wire logic       i_run,
  output logic            o_event
);
  import ccu_pkg::*;

  logic       sync_a;
  logic       sync_b;
  logic       last;
  logic [3:0] presc;
  logic       active;
  logic       rise;
  logic       fall;

  assign active = i_enable && is_capture(i_mode);
  assign rise   = sync_b && !last;
  assign fall   = !sync_b && last;

  // ----------------------------------------------------------------
  // synchronizer and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last   <= 1'b0;
    end else begin
      sync_a <= i_source;
      sync_b <= sync_a;
      last   <= sync_b;
    end
  end

  // ----------------------------------------------------------------
  // prescale counter
  // ----------------------------------------------------------------
  // counter is not cleared by a prescale change, only by reset, by disabling the unit or by leaving capture
  always_ff @(posedge i_clk) begin
    if (i_reset || !active) begin
      presc <= 4'h0;
    end else if (rise && i_run) begin
      presc <= presc + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || !active || !i_run) begin
      o_event <= 1'b0;
    end else begin
      unique case (i_mode)
        MODE_CAP_FALL:   o_event <= fall;
        MODE_CAP_RISE:   o_event <= rise;
        MODE_CAP_RISE4:  o_event <= rise && (presc[1:0] == PRESCALE_4[1:0]);
        MODE_CAP_RISE16: o_event <= rise && (presc == PRESCALE_16);
        default:         o_event <= 1'b0;
      endcase
    end
  end
endmodule // cap_event_detect

// ---- hw/compare_match.sv ----
`timescale 1ns/100ps
module compare_match (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_active,
  input  wire logic [15:0] i_ref,
  input  wire logic [15:0] i_count,
  output logic             o_match
);
  import ccu_pkg::*;

  logic equal_q;
  logic equal;

  assign equal = i_active && (i_ref == i_count);

  // one pulse per match episode; a count held by a timer prescaler
  // would otherwise fire every cycle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      equal_q <= 1'b0;
      o_match <= 1'b0;
    end else begin
      equal_q <= equal;
      o_match <= equal && !equal_q;
    end
  end
endmodule // compare_match

// ---- hw/capture_compare_unit.sv ----
`timescale 1ns/100ps
module capture_compare_unit (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // axi4-lite slave
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // timers and event sources
  input  wire logic [15:0] i_wide_timer_count,
  input  wire logic [15:0] i_base_timer_count,
  input  wire logic        i_remapped_pin_input,
  input  wire logic        i_comparator_one_out,
  input  wire logic        i_comparator_two_out,
  input  wire logic        i_numeric_oscillator,
  input  wire logic        i_pin_change_event,
  input  wire logic        i_logic_cell_one_out,
  input  wire logic        i_logic_cell_two_out,
  input  wire logic        i_logic_cell_three_out,
  input  wire logic        i_logic_cell_four_out,
  // system state
  input  wire logic        i_sleep,
  input  wire logic        i_timer_ext_clock,
  input  wire logic        i_trigger_selected,
  // outputs
  output logic             o_compare_out,
  output logic             o_conv_trigger,
  output logic             o_event_flag,
  output logic             o_wake,
  output logic             o_timer_hold,
  output logic [1:0]       o_timebase_sel
);
  import ccu_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic        unit_enable;
  logic        unit_fmt;
  logic [3:0]  event_mode_sel;
  logic [3:0]  capture_source_sel;
  logic [7:0]  hold_value_low;
  logic [7:0]  hold_value_high;
  logic        unit_event_flag;
  logic        unit_event_enable;
  logic        timer_source;
  logic        output_latch;

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;

  logic        cap_source;
  logic        cap_event;
  logic        cmp_match;
  logic        timer_run;
  logic [15:0] sel_count;
  logic        wr_ctl;
  logic        wr_flag;

  assign do_write  = aw_held && w_held && !o_bvalid;
  assign wr_ctl    = do_write && (aw_addr == OFF_CONTROL) && w_strb[0];
  assign wr_flag   = do_write && (aw_addr == OFF_FLAG) && w_strb[0];
  assign sel_count = timer_source ? i_base_timer_count : i_wide_timer_count;
  // instruction-clocked timer is frozen in sleep; external clock keeps it going
  assign timer_run = !i_sleep || i_timer_ext_clock;

  // ----------------------------------------------------------------
  // capture source select
  // ----------------------------------------------------------------
  // pin input is the pad level, so an output-driven pin changed by a
  // port write is seen like any external edge
  always_comb begin
    unique case (capture_source_sel)
      SRC_PIN:      cap_source = i_remapped_pin_input;
      SRC_CMP_ONE:  cap_source = i_comparator_one_out;
      SRC_CMP_TWO:  cap_source = i_comparator_two_out;
      SRC_NUM_OSC:  cap_source = i_numeric_oscillator;
      SRC_PIN_CHG:  cap_source = i_pin_change_event;
      SRC_LC_ONE:   cap_source = i_logic_cell_one_out;
      SRC_LC_TWO:   cap_source = i_logic_cell_two_out;
      SRC_LC_THREE: cap_source = i_logic_cell_three_out;
      SRC_LC_FOUR:  cap_source = i_logic_cell_four_out;
      default:      cap_source = 1'b0;
    endcase
  end

  cap_event_detect i_cap_event_detect (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_source (cap_source),
    .i_mode   (event_mode_sel),
    .i_enable (unit_enable),
    .i_run    (timer_run),
    .o_event  (cap_event)
  );

  compare_match i_compare_match (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_active (unit_enable && is_compare(event_mode_sel) && timer_run),
    .i_ref    ({hold_value_high, hold_value_low}),
    .i_count  (sel_count),
    .o_match  (cmp_match)
  );

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      aw_held   <= 1'b0;
      aw_addr   <= 8'h00;
      o_awready <= 1'b0;
    end else if (o_awready && i_awvalid) begin
      aw_held   <= 1'b1;
      aw_addr   <= i_awaddr;
      o_awready <= 1'b0;
    end else if (do_write) begin
      aw_held   <= 1'b0;
    end else begin
      o_awready <= !aw_held && !o_awready;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      w_held   <= 1'b0;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
      o_wready <= 1'b0;
    end else if (o_wready && i_wvalid) begin
      w_held   <= 1'b1;
      w_data   <= i_wdata;
      w_strb   <= i_wstrb;
      o_wready <= 1'b0;
    end else if (do_write) begin
      w_held   <= 1'b0;
    end else begin
      o_wready <= !w_held && !o_wready;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp  <= (aw_addr[7:5] == 3'h0 && aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // a mode change may leave a stale edge in flight; software clears the
  // flag afterwards, as for a prescale change made without disabling
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      unit_enable    <= 1'b0;
      unit_fmt       <= 1'b0;
      event_mode_sel <= MODE_OFF;
    end else if (wr_ctl) begin
      unit_enable    <= w_data[CTL_EN_BIT];
      unit_fmt       <= w_data[CTL_FMT_BIT];
      event_mode_sel <= w_data[3:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      capture_source_sel <= SRC_PIN;
      unit_event_enable  <= 1'b0;
      o_timebase_sel     <= 2'h0;
      timer_source       <= 1'b0;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == OFF_CAP_SRC) begin
        capture_source_sel <= w_data[3:0];
      end
      if (aw_addr == OFF_ENABLE) begin
        unit_event_enable <= w_data[0];
      end
      // only three timebases exist; the fourth code is ignored
      if (aw_addr == OFF_TIMEBASE && !(&w_data[1:0])) begin
        o_timebase_sel <= w_data[1:0];
      end
      if (aw_addr == OFF_TIMER_SEL) begin
        timer_source <= w_data[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // hold pair
  // ----------------------------------------------------------------
  // capture takes priority over a software write in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      hold_value_low  <= 8'h00;
      hold_value_high <= 8'h00;
    end else if (cap_event) begin
      hold_value_low  <= sel_count[7:0];
      hold_value_high <= sel_count[15:8];
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == OFF_HOLD_LOW) begin
        hold_value_low <= w_data[7:0];
      end
      if (aw_addr == OFF_HOLD_HIGH) begin
        hold_value_high <= w_data[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // event flag
  // ----------------------------------------------------------------
  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      unit_event_flag <= 1'b0;
    end else if (cap_event || cmp_match) begin
      unit_event_flag <= 1'b1;
    end else if (wr_flag) begin
      unit_event_flag <= w_data[0];
    end
  end

  // ----------------------------------------------------------------
  // compare output and trigger
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      output_latch <= 1'b0;
    end else if (wr_ctl && w_data[7:0] == 8'h00) begin
      output_latch <= 1'b0;
    end else if (cmp_match) begin
      unique case (event_mode_sel)
        MODE_CMP_TOGGLE: output_latch <= !output_latch;
        MODE_CMP_SET:    output_latch <= 1'b1;
        MODE_CMP_CLEAR:  output_latch <= 1'b0;
        default:         output_latch <= output_latch;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_conv_trigger <= 1'b0;
    end else begin
      o_conv_trigger <= cmp_match && (i_trigger_selected ||
                        event_mode_sel == MODE_CMP_TRIG);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_compare_out <= 1'b0;
      o_event_flag  <= 1'b0;
      o_wake        <= 1'b0;
      o_timer_hold  <= 1'b0;
    end else begin
      o_compare_out <= output_latch;
      o_event_flag  <= unit_event_flag;
      o_wake        <= i_sleep && unit_event_flag && unit_event_enable;
      o_timer_hold  <= i_sleep && !i_timer_ext_clock;
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= RESP_OKAY;
    end else if (o_arready && i_arvalid) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= RESP_OKAY;
      unique case (i_araddr)
        OFF_CONTROL:   o_rdata <= {24'h000000, unit_enable, 1'b0, output_latch,
                                   unit_fmt, event_mode_sel};
        OFF_CAP_SRC:   o_rdata <= {28'h0000000, capture_source_sel};
        OFF_HOLD_LOW:  o_rdata <= {24'h000000, hold_value_low};
        OFF_HOLD_HIGH: o_rdata <= {24'h000000, hold_value_high};
        OFF_FLAG:      o_rdata <= {31'h00000000, unit_event_flag};
        OFF_ENABLE:    o_rdata <= {31'h00000000, unit_event_enable};
        OFF_TIMEBASE:  o_rdata <= {30'h00000000, o_timebase_sel};
        OFF_TIMER_SEL: o_rdata <= {31'h00000000, timer_source};
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid) begin
      if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end else begin
      o_arready <= !o_arready;
    end
  end
endmodule // capture_compare_unit

// ---- testbench/capture_compare_unit_checker.sv ----
`timescale 1ns/100ps
module capture_compare_unit_checker
  import ccu_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic [7:0] i_awaddr,
  input wire logic       i_awvalid,
  input wire logic       o_awready,
  input wire logic       i_arvalid,
  input wire logic       o_arready,
  input wire logic       o_rvalid,
  input wire logic       i_sleep,
  input wire logic       i_timer_ext_clock,
  input wire logic       o_compare_out,
  input wire logic       o_conv_trigger,
  input wire logic       o_event_flag,
  input wire logic       o_wake,
  input wire logic       o_timer_hold,
  input wire logic [1:0] o_timebase_sel
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // ----------------------------------------------------------------
  // helper
  // ----------------------------------------------------------------
  // age from reset too, so a flag dropped by reset is not blamed
  logic [3:0] flag_wr_age;
  always_ff @(posedge i_clk) begin
    if (i_reset || (i_awvalid && o_awready && i_awaddr == OFF_FLAG)) begin
      flag_wr_age <= 4'h0;
    end else if (flag_wr_age != 4'hf) begin
      flag_wr_age <= flag_wr_age + 4'h1;
    end
  end

  sequence s_ar_taken;
    i_arvalid && o_arready;
  endsequence
  sequence s_long_halt;
    o_timer_hold [*4];
  endsequence

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_flag_soft_clear: assert property ($fell(o_event_flag) |-> flag_wr_age < 4'h6)
    else $error("event flag fell without a flag write");
  a_trig_one_cycle: assert property (o_conv_trigger |=> !o_conv_trigger)
    else $error("converter trigger longer than one cycle");
  a_trig_sets_flag: assert property (o_conv_trigger |-> ##[0:2] o_event_flag)
    else $error("trigger without event flag");
  a_pin_with_flag: assert property ($rose(o_compare_out) |-> ##[0:1] o_event_flag)
    else $error("pin action without event flag");
  a_sleep_quiet: assert property (s_long_halt |-> !o_conv_trigger)
    else $error("trigger while timer frozen");
  a_wake_cause: assert property (o_wake |-> $past(i_sleep) && o_event_flag)
    else $error("wake without sleep and flag");
  a_hold_follows: assert property (!$past(i_reset) |->
    o_timer_hold == ($past(i_sleep) && !$past(i_timer_ext_clock)))
    else $error("timer hold does not follow sleep");
  a_read_answer: assert property (s_ar_taken |=> o_rvalid)
    else $error("read data late");
  a_three_timers: assert property (o_timebase_sel != 2'h3)
    else $error("timebase choice out of range");
endmodule // capture_compare_unit_checker

bind capture_compare_unit capture_compare_unit_checker i_capture_compare_unit_checker (
  .i_clk, .i_reset, .i_awaddr, .i_awvalid, .o_awready, .i_arvalid, .o_arready,
  .o_rvalid, .i_sleep, .i_timer_ext_clock, .o_compare_out, .o_conv_trigger,
  .o_event_flag, .o_wake, .o_timer_hold, .o_timebase_sel
);

// ---- testbench/timer_source_model.sv ----
`timescale 1ns/100ps
module timer_source_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_run,
  input  wire logic        i_hold,
  input  wire logic [8:0]  i_level,
  output logic      [15:0] o_wide,
  output logic      [15:0] o_base,
  output logic      [8:0]  o_src
);
  // synchronous count at instruction rate, no prescale, frozen on hold
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_wide <= 16'h1230;
      o_base <= 16'h8001;
    end else if (i_run && !i_hold) begin
      o_wide <= o_wide + 16'h0001;
      o_base <= o_base + 16'h0003;
    end
  end

  // sources change only off the clock edge, like on-chip logic
  always_ff @(posedge i_clk) begin
    o_src <= i_level;
  end
endmodule // timer_source_model

// ---- testbench/capture_compare_unit_bench.sv ----
`timescale 1ns/100ps
module capture_compare_unit_bench;
  import ccu_pkg::*;
  logic        i_clk = 1'b0, i_reset = 1'b1, run = 1'b0;
  logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, rdat;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_arvalid = 1'b0;
  logic        i_sleep = 1'b0, i_timer_ext_clock = 1'b0, i_trigger_selected = 1'b0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp, o_timebase_sel, rsp;
  logic [15:0] i_wide_timer_count, i_base_timer_count;
  logic        o_compare_out, o_conv_trigger, o_event_flag, o_wake, o_timer_hold;
  logic [8:0]  level = 9'h0, src;
  int          n_errors = 0, checked = 0, trigs = 0;
  // rows: source, mode, timer select, flag after rising edge
  logic [15:0] cap_rows [10] = '{16'h0501, 16'h1511, 16'h2501, 16'h3511, 16'h4501,
                                 16'h5511, 16'h6501, 16'h7511, 16'h8501, 16'h0400};
  // rows: mode, trigger selected, pin after match, triggers seen
  logic [15:0] cmp_rows [7] = '{16'h8010, 16'h2000, 16'h2010, 16'ha010, 16'h9101,
                                16'hb001, 16'h8111};

  capture_compare_unit i_capture_compare_unit (
    .i_clk, .i_reset, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb(4'hf),
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready(1'b1), .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready(1'b1),
    .i_wide_timer_count, .i_base_timer_count, .i_remapped_pin_input(src[0]),
    .i_comparator_one_out(src[1]), .i_comparator_two_out(src[2]),
    .i_numeric_oscillator(src[3]), .i_pin_change_event(src[4]),
    .i_logic_cell_one_out(src[5]), .i_logic_cell_two_out(src[6]),
    .i_logic_cell_three_out(src[7]), .i_logic_cell_four_out(src[8]),
    .i_sleep, .i_timer_ext_clock, .i_trigger_selected, .o_compare_out,
    .o_conv_trigger, .o_event_flag, .o_wake, .o_timer_hold, .o_timebase_sel
  );
  timer_source_model i_timer_source_model (
    .i_clk, .i_reset, .i_run(run), .i_hold(o_timer_hold), .i_level(level),
    .o_wide(i_wide_timer_count), .o_base(i_base_timer_count), .o_src(src)
  );

  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_conv_trigger === 1'b1) trigs++;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    checked++;
    if (seen !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    rsp = o_bresp;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    rdat = o_rdata;
    rsp = o_rresp;
  endtask
  task automatic expect_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd_reg(a);
    check(nm, rdat, e);
  endtask
  task automatic set_src(input int k, input logic v);
    level[k] <= v;
    cyc(6);
  endtask
  task automatic arm(input logic [3:0] s, input logic [3:0] m);
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_CAP_SRC, {28'h0, s});
    wr(OFF_CONTROL, {24'h0, 4'h8, m});
    wr(OFF_FLAG, 32'h0);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [3:0]  s, m, t, f;
    logic [15:0] want;
    int          n0;
    cyc(20);
    i_reset <= 1'b0;
    expect_reg("control", OFF_CONTROL, 32'h0);
    expect_reg("flag", OFF_FLAG, 32'h0);
    expect_reg("hold low", OFF_HOLD_LOW, 32'h0);
    check("pin", o_compare_out, 1'b0);
    $display("reset test done");
    foreach (cap_rows[i]) begin
      {s, m, t, f} = cap_rows[i];
      wr(OFF_TIMER_SEL, {28'h0, t});
      arm(s, m);
      expect_reg("control", OFF_CONTROL, {24'h0, 4'h8, m});
      run <= 1'b1;
      cyc(5 + i);
      run <= 1'b0;
      cyc(2);
      want = t[0] ? i_base_timer_count : i_wide_timer_count;
      set_src(s, 1'b1);
      expect_reg("flag on rise", OFF_FLAG, {31'h0, f[0]});
      set_src(s, 1'b0);
      expect_reg("flag", OFF_FLAG, 32'h1);
      expect_reg("hold low", OFF_HOLD_LOW, {24'h0, want[7:0]});
      expect_reg("hold high", OFF_HOLD_HIGH, {24'h0, want[15:8]});
    end
    $display("capture rows done");
    for (int j = 0; j < 2; j++) begin
      arm(4'h0, j ? MODE_CAP_RISE16 : MODE_CAP_RISE4);
      repeat (j ? 15 : 3) begin
        set_src(0, 1'b1);
        set_src(0, 1'b0);
      end
      expect_reg("prescale short", OFF_FLAG, 32'h0);
      set_src(0, 1'b1);
      set_src(0, 1'b0);
      expect_reg("prescale full", OFF_FLAG, 32'h1);
    end
    arm(4'h0, MODE_CAP_RISE4);
    repeat (2) begin
      set_src(0, 1'b1);
      set_src(0, 1'b0);
    end
    arm(4'h0, MODE_CAP_RISE4);
    repeat (3) begin
      set_src(0, 1'b1);
      set_src(0, 1'b0);
    end
    expect_reg("prescale cleared", OFF_FLAG, 32'h0);
    arm(4'h0, MODE_CAP_RISE);
    wr(OFF_TIMER_SEL, 32'h0);
    set_src(0, 1'b1);
    run <= 1'b1;
    cyc(9);
    run <= 1'b0;
    cyc(2);
    want = i_wide_timer_count;
    set_src(0, 1'b0);
    set_src(0, 1'b1);
    expect_reg("overwrite", OFF_HOLD_LOW, {24'h0, want[7:0]});
    $display("prescale and overwrite done");
    foreach (cmp_rows[i]) begin
      {m, t, s, f} = cmp_rows[i];
      i_trigger_selected <= t[0];
      wr(OFF_CONTROL, {24'h0, 4'h8, m});
      wr(OFF_FLAG, 32'h0);
      want = i_wide_timer_count + 16'h0014;
      wr(OFF_HOLD_LOW, {24'h0, want[7:0]});
      wr(OFF_HOLD_HIGH, {24'h0, want[15:8]});
      n0 = trigs;
      run <= 1'b1;
      cyc(40);
      run <= 1'b0;
      cyc(6);
      check("pin", o_compare_out, s[0]);
      check("triggers", trigs - n0, f);
      check("event flag out", o_event_flag, 1'b1);
      expect_reg("flag", OFF_FLAG, 32'h1);
    end
    wr(OFF_CONTROL, 32'h0);
    cyc(4);
    check("pin cleared", o_compare_out, 1'b0);
    $display("compare rows done");
    arm(4'h0, MODE_CAP_RISE);
    wr(OFF_ENABLE, 32'h1);
    i_sleep <= 1'b1;
    run <= 1'b1;
    cyc(3);
    want = i_wide_timer_count;
    set_src(0, 1'b1);
    set_src(0, 1'b0);
    check("timer hold", o_timer_hold, 1'b1);
    check("frozen count", i_wide_timer_count, want);
    expect_reg("sleep flag", OFF_FLAG, 32'h0);
    i_timer_ext_clock <= 1'b1;
    set_src(0, 1'b1);
    expect_reg("ext flag", OFF_FLAG, 32'h1);
    check("wake", o_wake, 1'b1);
    i_sleep <= 1'b0;
    run <= 1'b0;
    $display("sleep test done");
    wr(OFF_TIMEBASE, 32'h2);
    cyc(2);
    check("timebase", o_timebase_sel, 2'h2);
    wr(OFF_TIMEBASE, 32'h3);
    expect_reg("timebase", OFF_TIMEBASE, 32'h2);
    wr(8'h24, 32'h5);
    check("bad write", rsp, RESP_SLVERR);
    expect_reg("bad read", 8'h24, 32'h0);
    check("bad read resp", rsp, RESP_SLVERR);
    $display("register test done");
    close_out();
  end
endmodule // capture_compare_unit_bench
